// *** hdl/can_fd_send_request_consts.vh ***
// Purpose: constants for the CAN FD request and error status slice
// Assumes: APB byte address is four times the register index
// Notes: indices are the printed register offsets
`ifndef CAN_FD_SEND_REQUEST_CONSTS_VH
`define CAN_FD_SEND_REQUEST_CONSTS_VH

// ****************************************************************
// register indices
// ****************************************************************
`define IDX_RX_OVF_SUM_HI 14'h05EA
`define IDX_TX_ATT_SUM_LO 14'h05EC
`define IDX_TX_ATT_SUM_HI 14'h05EE
`define IDX_SEND_REQ_LO 14'h05F0
`define IDX_SEND_REQ_HI 14'h05F2
`define IDX_ERR_CNT_PAIR 14'h05F4
`define IDX_ERR_STATE 14'h05F6
`define IDX_NOM_ERR_CNT 14'h05F8
`define IDX_FAST_ERR_CNT 14'h05FA

// ****************************************************************
// fields, thresholds and reset values
// ****************************************************************
`define OPMODE_CONFIG 3'h4
`define TEC_INC 9'h008
`define TEC_DEC 9'h001
`define TEC_BUSOFF_LIM 9'h0FF
`define TEC_SAT 9'h100
`define ERR_PASSIVE_LIM 9'h07F
`define ERR_WARN_LO 9'h05F
`define ERR_WARN_HI 9'h080
`define REC_DEC 8'h01
`define CNT8_MAX 8'hFF
`define STATE_RESET 6'h20
`define SREQ_RESET 8'h00
`define ST_BUS_OFF 5
`define ST_TX_PASSIVE 4
`define ST_RX_PASSIVE 3
`define ST_TX_WARN 2
`define ST_RX_WARN 1
`define ST_ANY_WARN 0
`endif

// *** hdl/can_fd_send_request_error_status.v ***
// Purpose: send request, attempt summary and error counter registers
// Assumes: APB slave, zero wait state, protocol engine events in pclk
// Notes: 16-bit registers sit in the low half of each 32-bit word
//
// Behaviour
// - summaries read-only; flags cleared in FIFOs
// - attempt summary low byte, bit0 queue
// - attempt bit reads one when pending
// - objects 8 to 31 read zero
// - write one requests send, hardware clears
// - writing zero never cancels a send
// - receive objects ignore send request
// - send request bit 0 serves queue
// - tx and rx error counts, read-only
// - bus off when tx count above 255
// - bus off resets set, held in configuration
// - tx passive when tx count above 127
// - rx passive when rx count above 127
// - tx warning between 95 and 128
// - rx warning between 95 and 128
// - any warning is tx or rx warning
// - nominal rate tx rx counters, read-write
// - data rate tx rx counters, read-write
// - configuration mode is mode value 100
`timescale 1ns/100ps
`include "can_fd_send_request_consts.vh"

module can_fd_send_request_error_status (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [2:0] operation_mode_field,
   input wire [7:1] object_is_transmitter,
   input wire [7:0] tx_attempt_pending,
   input wire [7:0] object_sent,
   input wire tx_error_event,
   input wire rx_error_event,
   input wire tx_success,
   input wire rx_success,
   input wire fast_phase,
   input wire bus_off_recovered,
   output reg [7:0] send_request,
   output reg bus_off_state,
   output reg tx_passive_state,
   output reg rx_passive_state,
   output reg any_warning_state
);

   // ************************************************************
   // functions
   // ************************************************************
   function hit;
      input [15:0] addr;
      input [13:0] idx;
      begin
         hit = (addr[15:2] == idx);
      end
   endfunction

   function [7:0] sat_inc;
      input [7:0] v;
      begin
         if (v == `CNT8_MAX) begin
            sat_inc = v;
         end else begin
            sat_inc = v + 8'h01;
         end
      end
   endfunction

   function [7:0] sat_dec;
      input [7:0] v;
      begin
         if (v == 8'h00) begin
            sat_dec = v;
         end else begin
            sat_dec = v - `REC_DEC;
         end
      end
   endfunction

   function warn_band;
      input [8:0] v;
      begin
         warn_band = (v > `ERR_WARN_LO) && (v < `ERR_WARN_HI);
      end
   endfunction

   function passive_band;
      input [8:0] v;
      begin
         passive_band = (v > `ERR_PASSIVE_LIM);
      end
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   reg [8:0] tec_r;
   reg [8:0] tec_nxt;
   reg [7:0] rec_r;
   reg [7:0] rec_nxt;
   reg [7:0] nom_tx_r;
   reg [7:0] nom_tx_nxt;
   reg [7:0] nom_rx_r;
   reg [7:0] nom_rx_nxt;
   reg [7:0] fast_tx_r;
   reg [7:0] fast_tx_nxt;
   reg [7:0] fast_rx_r;
   reg [7:0] fast_rx_nxt;
   reg [5:0] state_r;
   reg [5:0] state_nxt;
   reg [7:0] sreq_nxt;
   reg [15:0] rd_data;
   reg mapped;
   reg [9:0] tec_sum;
   wire cfg_mode;
   wire setup;
   wire wr_en;
   wire [7:0] tec_view;
   wire [7:0] tx_allow;
   wire wr_sreq;
   wire wr_nom;
   wire wr_fast;

   assign cfg_mode = (operation_mode_field == `OPMODE_CONFIG);
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite;
   assign tec_view = (tec_r > `TEC_BUSOFF_LIM) ? `CNT8_MAX : tec_r[7:0];
   assign tx_allow = {object_is_transmitter, 1'b1};
   assign wr_sreq = wr_en & hit(paddr, `IDX_SEND_REQ_LO);
   assign wr_nom = wr_en & hit(paddr, `IDX_NOM_ERR_CNT);
   assign wr_fast = wr_en & hit(paddr, `IDX_FAST_ERR_CNT);

   // ************************************************************
   // address decode and read data
   // ************************************************************
   always @* begin
      mapped = 1'b1;
      rd_data = 16'h0000;
      case (1'b1)
         hit(paddr, `IDX_RX_OVF_SUM_HI): begin
            rd_data = 16'h0000;
         end
         hit(paddr, `IDX_TX_ATT_SUM_LO): begin
            rd_data = {8'h00, tx_attempt_pending};
         end
         hit(paddr, `IDX_TX_ATT_SUM_HI): begin
            rd_data = 16'h0000;
         end
         hit(paddr, `IDX_SEND_REQ_LO): begin
            rd_data = {8'h00, send_request};
         end
         hit(paddr, `IDX_SEND_REQ_HI): begin
            rd_data = 16'h0000;
         end
         hit(paddr, `IDX_ERR_CNT_PAIR): begin
            rd_data = {tec_view, rec_r};
         end
         hit(paddr, `IDX_ERR_STATE): begin
            rd_data = {10'h000, state_r};
         end
         hit(paddr, `IDX_NOM_ERR_CNT): begin
            rd_data = {nom_tx_r, nom_rx_r};
         end
         hit(paddr, `IDX_FAST_ERR_CNT): begin
            rd_data = {fast_tx_r, fast_rx_r};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // send requests
   // ************************************************************
   always @* begin
      sreq_nxt = send_request & ~object_sent;
      if (wr_sreq && pstrb[0]) begin
         // ones set, zeros leave bits alone, set wins over clear
         sreq_nxt = sreq_nxt | (pwdata[7:0] & tx_allow);
      end
   end

   // ************************************************************
   // protocol error counters
   // ************************************************************
   always @* begin
      tec_sum = {1'b0, tec_r} + {1'b0, `TEC_INC};
      tec_nxt = tec_r;
      rec_nxt = rec_r;
      if (cfg_mode || bus_off_recovered) begin
         tec_nxt = 9'h000;
         rec_nxt = 8'h00;
      end else begin
         if (tx_error_event) begin
            if (tec_sum > {1'b0, `TEC_SAT}) begin
               tec_nxt = `TEC_SAT;
            end else begin
               tec_nxt = tec_sum[8:0];
            end
         end else if (tx_success && tec_r != 9'h000 &&
                      tec_r <= `TEC_BUSOFF_LIM) begin
            tec_nxt = tec_r - `TEC_DEC;
         end
         if (rx_error_event) begin
            rec_nxt = sat_inc(rec_r);
         end else if (rx_success) begin
            rec_nxt = sat_dec(rec_r);
         end
      end
   end

   // ************************************************************
   // phase error counters
   // ************************************************************
   always @* begin
      nom_tx_nxt = nom_tx_r;
      nom_rx_nxt = nom_rx_r;
      fast_tx_nxt = fast_tx_r;
      fast_rx_nxt = fast_rx_r;
      if (wr_nom) begin
         if (pstrb[1]) begin
            nom_tx_nxt = pwdata[15:8];
         end
         if (pstrb[0]) begin
            nom_rx_nxt = pwdata[7:0];
         end
      end
      if (wr_fast) begin
         if (pstrb[1]) begin
            fast_tx_nxt = pwdata[15:8];
         end
         if (pstrb[0]) begin
            fast_rx_nxt = pwdata[7:0];
         end
      end
      if (tx_error_event && !fast_phase) begin
         nom_tx_nxt = sat_inc(nom_tx_nxt);
      end
      if (rx_error_event && !fast_phase) begin
         nom_rx_nxt = sat_inc(nom_rx_nxt);
      end
      if (tx_error_event && fast_phase) begin
         fast_tx_nxt = sat_inc(fast_tx_nxt);
      end
      if (rx_error_event && fast_phase) begin
         fast_rx_nxt = sat_inc(fast_rx_nxt);
      end
   end

   // ************************************************************
   // error state bits
   // ************************************************************
   always @* begin
      state_nxt = 6'h00;
      state_nxt[`ST_BUS_OFF] = cfg_mode ||
                              (tec_r > `TEC_BUSOFF_LIM);
      state_nxt[`ST_TX_PASSIVE] = passive_band(tec_r);
      state_nxt[`ST_RX_PASSIVE] = passive_band({1'b0, rec_r});
      state_nxt[`ST_TX_WARN] = warn_band(tec_r);
      state_nxt[`ST_RX_WARN] = warn_band({1'b0, rec_r});
      state_nxt[`ST_ANY_WARN] = state_nxt[`ST_TX_WARN] |
                                state_nxt[`ST_RX_WARN];
   end

   // ************************************************************
   // registers
   // ************************************************************
   // bus response: ready and error stand for the access cycle only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= {16'h0000, rd_data};
         end
      end
   end

   // ************************************************************
   // send request register
   // ************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         send_request <= `SREQ_RESET;
      end else begin
         send_request <= sreq_nxt;
      end
   end

   // ************************************************************
   // counter registers
   // ************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tec_r <= 9'h000;
         rec_r <= 8'h00;
         nom_tx_r <= 8'h00;
         nom_rx_r <= 8'h00;
         fast_tx_r <= 8'h00;
         fast_rx_r <= 8'h00;
      end else begin
         tec_r <= tec_nxt;
         rec_r <= rec_nxt;
         nom_tx_r <= nom_tx_nxt;
         nom_rx_r <= nom_rx_nxt;
         fast_tx_r <= fast_tx_nxt;
         fast_rx_r <= fast_rx_nxt;
      end
   end

   // ************************************************************
   // error state registers
   // ************************************************************
   // the state outputs mirror the register bits in separate flops loaded from state_nxt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= `STATE_RESET;
         bus_off_state <= 1'b1;
         tx_passive_state <= 1'b0;
         rx_passive_state <= 1'b0;
         any_warning_state <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bus_off_state <= state_nxt[`ST_BUS_OFF];
         tx_passive_state <= state_nxt[`ST_TX_PASSIVE];
         rx_passive_state <= state_nxt[`ST_RX_PASSIVE];
         any_warning_state <= state_nxt[`ST_ANY_WARN];
      end
   end

endmodule // can_fd_send_request_error_status

// *** dv/can_fd_send_request_error_status_asserts.sv ***
// Purpose: port checks for the status slice
// Assumes: zero wait APB slave
// Notes: bound after the module
`timescale 1ns/100ps
module can_fd_send_request_error_status_asserts (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [15:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [2:0] operation_mode_field,
   input wire [7:1] object_is_transmitter,
   input wire [7:0] tx_attempt_pending,
   input wire [7:0] object_sent,
   input wire [7:0] send_request,
   input wire bus_off_state,
   input wire tx_passive_state,
   input wire rx_passive_state,
   input wire any_warning_state
);
// ********
// checks
// ********
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire setup = psel && !penable;
AST_READY: assert property (setup |=> pready) else $error("no ready");
AST_ERR: assert property (pslverr |-> pready) else $error("lone error");
AST_UNMAPPED: assert property (setup && paddr[15:8] != 8'h17 |=> pslverr)
   else $error("unmapped accepted");
AST_ATT_READ: assert property (setup && paddr == 16'h17B0 |=>
   prdata == {24'h0, $past(tx_attempt_pending)}) else $error("bad summary");
AST_ATT_HIGH: assert property (setup && paddr == 16'h17B8 |=>
   prdata == 32'h0) else $error("high summary set");
AST_RX_OBJ: assert property ((send_request[7:1]
   & ~$past(send_request[7:1])
   & ~$past(object_is_transmitter)) == 7'h00) else $error("rx object set");
AST_NO_CANCEL: assert property ((~send_request & $past(send_request)
   & ~$past(object_sent)) == 8'h00) else $error("send cancelled");
AST_CFG_BUS_OFF: assert property ((operation_mode_field == 3'h4)[*3]
   |-> bus_off_state) else $error("bus off clear in config");
AST_CFG_QUIET: assert property ((operation_mode_field == 3'h4)[*4] |->
   !(tx_passive_state | rx_passive_state | any_warning_state))
   else $error("state set in config");
cover property (setup && paddr == 16'h17C0);
cover property (pslverr);
cover property (bus_off_state && operation_mode_field == 3'h0);
cover property (any_warning_state);
endmodule // can_fd_send_request_error_status_asserts
bind can_fd_send_request_error_status can_fd_send_request_error_status_asserts chk (.*);

// *** dv/can_bus_node_model.sv ***
// Purpose: far side event source for the status slice
// Assumes: one event per request cycle
// Notes: pulses last one cycle; phase level held
`timescale 1ns/100ps
module can_bus_node_model (
   input wire pclk,
   input wire presetn,
   input wire req,
   input wire [2:0] kind,
   input wire ph,
   input wire [7:0] obj,
   output reg tx_error_event,
   output reg rx_error_event,
   output reg tx_success,
   output reg rx_success,
   output reg bus_off_recovered,
   output reg fast_phase,
   output reg [7:0] object_sent
);
// ********
// event pulses
// ********
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      {tx_error_event, rx_error_event, tx_success, rx_success} <= 4'h0;
      {bus_off_recovered, fast_phase, object_sent} <= 10'h000;
   end else begin
      {bus_off_recovered, rx_success, tx_success, rx_error_event,
         tx_error_event} <= req ? 5'h01 << kind : 5'h00;
      object_sent <= (req && kind == 3'h5) ? obj : 8'h00;
      fast_phase <= req ? ph : fast_phase;
   end
end
endmodule // can_bus_node_model

// *** dv/can_fd_send_request_error_status_tb.sv ***
// Purpose: self-checking bench for the status slice
// Assumes: zero wait APB, events from the node model
// Notes: LFSR stimulus, expected counts kept by the bench
`timescale 1ns/100ps
`include "can_fd_send_request_consts.vh"
module can_fd_send_request_error_status_tb;
// ********
// bench
// ********
reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req = 0, ph = 0;
reg [15:0] paddr = 16'h0000;
reg [31:0] pwdata = 32'h0, lfsr = 32'h465B87A8, q;
reg [3:0] pstrb = 4'hF;
reg [2:0] operation_mode_field = 3'h4, kind = 3'h0;
reg [7:1] object_is_transmitter = 7'h55, m;
reg [7:0] tx_attempt_pending = 8'h00, obj = 8'h00;
reg [7:0] rec = 0, ntx = 0, nrx = 0, dtx = 0, drx = 0;
reg [8:0] tec = 0;
reg e;
wire [31:0] prdata;
wire [7:0] object_sent, send_request;
wire pready, pslverr, tx_error_event, rx_error_event, tx_success, rx_success;
wire fast_phase, bus_off_recovered, bus_off_state, tx_passive_state;
wire rx_passive_state, any_warning_state;
integer err_count = 0, n_compared = 0, i, n;
localparam [15:0] A_OVF = {`IDX_RX_OVF_SUM_HI, 2'b00},
   A_ATL = {`IDX_TX_ATT_SUM_LO, 2'b00}, A_ATH = {`IDX_TX_ATT_SUM_HI, 2'b00},
   A_SRL = {`IDX_SEND_REQ_LO, 2'b00}, A_SRH = {`IDX_SEND_REQ_HI, 2'b00},
   A_PAIR = {`IDX_ERR_CNT_PAIR, 2'b00}, A_ST = {`IDX_ERR_STATE, 2'b00},
   A_NOM = {`IDX_NOM_ERR_CNT, 2'b00}, A_FAST = {`IDX_FAST_ERR_CNT, 2'b00};
can_fd_send_request_error_status dut (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .operation_mode_field,
   .object_is_transmitter, .tx_attempt_pending, .object_sent, .tx_error_event,
   .rx_error_event, .tx_success, .rx_success, .fast_phase, .bus_off_recovered,
   .send_request, .bus_off_state, .tx_passive_state, .rx_passive_state,
   .any_warning_state);
can_bus_node_model node (.pclk, .presetn, .req, .kind, .ph, .obj,
   .tx_error_event, .rx_error_event, .tx_success, .rx_success,
   .bus_off_recovered, .fast_phase, .object_sent);
initial forever #20 pclk = ~pclk;
function [31:0] rnd(input [31:0] s);
   rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
function [7:0] inc8(input [7:0] x);
   inc8 = (x == 8'hFF) ? x : x + 8'h01;
endfunction
function [31:0] st_exp(input [8:0] t, input [7:0] r, input c);
   st_exp = {26'h0, c | t[8], t > 9'h07F, r[7], t[8:5] == 4'h3,
      r[7:5] == 3'h3, t[8:5] == 4'h3 || r[7:5] == 3'h3};
endfunction
task report_and_stop;
   begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
endtask
task chk(input [31:0] g, input [31:0] x);
   begin
      n_compared = n_compared + 1;
      if (g !== x) begin
         err_count = err_count + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
      end
   end
endtask
task apb(input [15:0] a, input w, input [15:0] d, input [31:0] x);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count = err_count + 1;
         report_and_stop;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (!w)
         chk(q, x);
   end
endtask
task rd(input [15:0] a, input [31:0] x);
   apb(a, 1'b0, 16'h0000, x);
endtask
task wr(input [15:0] a, input [15:0] d);
   apb(a, 1'b1, d, 32'h0);
endtask
task ev(input [2:0] k, input p, input [7:0] o);
   begin
      @(posedge pclk);
      req <= 1'b1;
      kind <= k;
      ph <= p;
      obj <= o;
      @(posedge pclk);
      req <= 1'b0;
      @(posedge pclk);
      case (k)
         3'h0: tec = tec > 9'h0F7 ? 9'h100 : tec + 9'h008;
         3'h1: rec = inc8(rec);
         3'h2: tec = (tec == 9'h000 || tec[8]) ? tec : tec - 9'h001;
         3'h3: rec = (rec == 8'h00) ? rec : rec - 8'h01;
         3'h4: {tec, rec} = 17'h00000;
         default: ;
      endcase
      if (k == 3'h0)
         {dtx, ntx} = p ? {inc8(dtx), ntx} : {dtx, inc8(ntx)};
      if (k == 3'h1)
         {drx, nrx} = p ? {inc8(drx), nrx} : {drx, inc8(nrx)};
   end
endtask
task chk_all;
   begin
      rd(A_PAIR, {16'h0, tec[8] ? 8'hFF : tec[7:0], rec});
      rd(A_ST, st_exp(tec, rec, operation_mode_field == 3'h4));
      rd(A_NOM, {16'h0, ntx, nrx});
      rd(A_FAST, {16'h0, dtx, drx});
      q = st_exp(tec, rec, operation_mode_field == 3'h4);
      chk({28'h0, bus_off_state, tx_passive_state, rx_passive_state,
         any_warning_state}, {28'h0, q[5:3], q[0]});
   end
endtask
initial begin
   repeat (6) @(posedge pclk);
   presetn <= 1'b1;
   wr(A_PAIR, 16'hFFFF);
   chk_all;
   rd(A_OVF, 32'h0);
   wr(A_ATH, 16'hFFFF);
   rd(A_ATH, 32'h0);
   $display("reset values done");
   operation_mode_field <= 3'h0;
   for (i = 0; i < 4; i = i + 1) begin
      lfsr = rnd(lfsr);
      tx_attempt_pending <= lfsr[7:0];
      rd(A_ATL, {24'h0, lfsr[7:0]});
   end
   m = lfsr[15:9];
   object_is_transmitter <= m;
   wr(A_SRL, 16'h00FF);
   rd(A_SRL, {24'h0, m, 1'b1});
   chk({24'h0, send_request}, {24'h0, m, 1'b1});
   wr(A_SRL, 16'h0000);
   wr(A_SRH, 16'hFFFF);
   rd(A_SRL, {24'h0, m, 1'b1});
   rd(A_SRH, 32'h0);
   ev(3'h5, 1'b0, 8'h01);
   rd(A_SRL, {24'h0, m, 1'b0});
   ev(3'h5, 1'b0, {m, 1'b0});
   rd(A_SRL, 32'h0);
   wr(16'h1000, 16'hFFFF);
   chk({31'h0, e}, 32'h1);
   $display("send request done");
   repeat (96) ev(3'h1, 1'b1, 8'h00);
   chk_all;
   ev(3'h3, 1'b0, 8'h00);
   chk_all;
   repeat (12) ev(3'h0, 1'b0, 8'h00);
   chk_all;
   ev(3'h2, 1'b0, 8'h00);
   chk_all;
   for (i = 0; i < 150; i = i + 1) begin
      lfsr = rnd(lfsr);
      ev({1'b0, lfsr[1:0]}, lfsr[4], 8'h00);
      chk_all;
   end
   ev(3'h4, 1'b0, 8'h00);
   wr(A_NOM, lfsr[15:0]);
   {ntx, nrx} = lfsr[15:0];
   pstrb <= 4'h2;
   wr(A_FAST, 16'hA5A5);
   dtx = 8'hA5;
   pstrb <= 4'hF;
   chk_all;
   operation_mode_field <= 3'h4;
   {tec, rec} = 17'h00000;
   repeat (4) @(posedge pclk);
   chk_all;
   $display("counters done");
   report_and_stop;
end
endmodule // can_fd_send_request_error_status_tb
